// >>> src/cfpe_pkg.sv
// Constants, types and helper functions of the CAN frame engine
package cfpe_pkg;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [6:0] POS_IDE = 7'h0d;
  localparam logic [6:0] ARB_STD_LAST = 7'h0d;
  localparam logic [6:0] ARB_EXT_LAST = 7'h20;
  localparam logic [6:0] HEAD_STD_LAST = 7'h12;
  localparam logic [6:0] HEAD_EXT_LAST = 7'h26;
  localparam logic [6:0] CRC_LAST = 7'h0e;
  localparam logic [6:0] FLAG_LAST = 7'h05;
  localparam logic [6:0] DELIM_LAST = 7'h07;
  localparam logic [6:0] EOF_LAST = 7'h06;
  localparam logic [6:0] INTER_LAST = 7'h02;
  localparam logic [6:0] SUSP_LAST = 7'h07;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [3:0] IDLE_RUN = 4'hb;
  localparam logic [1:0] MAX_OVL = 2'h2;
  localparam int RTR_BACK = 6;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 8;
  localparam int TXSH_W = 103;
  localparam logic DOM = 1'b0;
  localparam logic REC = 1'b1;

  typedef struct packed {
    logic ide;
    logic rtr;
    logic [28:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } cfpe_frame_t;

  typedef struct packed {
    logic ide;
    logic rtr;
    logic [28:0] id;
    logic [3:0] dlc;
  } cfpe_hdr_t;

  typedef enum logic [12:0] {
    S_IDLE = 13'h0001, S_HEAD = 13'h0002, S_DATA = 13'h0004, S_CRC = 13'h0008,
    S_CRCD = 13'h0010, S_ACK = 13'h0020, S_ACKD = 13'h0040, S_EOF = 13'h0080,
    S_INTER = 13'h0100, S_SUSP = 13'h0200, S_FLAG = 13'h0400, S_DWAIT = 13'h0800,
    S_DELIM = 13'h1000
  } cfpe_state_t;

  function automatic logic [14:0] crc_step(input logic [14:0] crc, input logic b);
    crc_step = {crc[13:0], 1'b0} ^ ((b ^ crc[14]) ? CRC_POLY : 15'h0000);
  endfunction : crc_step

  function automatic logic [3:0] dlc_bytes(input logic [3:0] dlc);
    dlc_bytes = dlc[3] ? 4'h8 : {1'b0, dlc[2:0]};
  endfunction : dlc_bytes

  // Serial image, first bit in the top position, SOF included
  function automatic logic [102:0] tx_image(input cfpe_frame_t f);
    if (f.ide) begin
      tx_image = {DOM, f.id[28:18], REC, REC, f.id[17:0], f.rtr, REC, REC, f.dlc, f.data};
    end else begin
      tx_image = {DOM, f.id[10:0], f.rtr, DOM, REC, f.dlc, f.data, 20'h00000};
    end
  endfunction : tx_image
endpackage : cfpe_pkg

// >>> src/cfpe_fifo.sv
// Parameterised valid/ready FIFO for received data bytes
`timescale 1ns/100ps
module cfpe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, rd_r;
  logic [AW:0] count_r, count_nxt;
  logic in_ready_r, out_valid_r, push, pop;

  assign push = in_valid && in_ready_r;
  assign pop = out_valid_r && out_ready;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = mem[rd_r];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b1;
      out_valid_r <= 1'b0;
    end else begin
      wr_r <= wr_r + AW'(push);
      rd_r <= rd_r + AW'(pop);
      count_r <= count_nxt;
      in_ready_r <= count_nxt != (AW+1)'(DEPTH);
      out_valid_r <= count_nxt != '0;
    end
  end
endmodule : cfpe_fifo

// >>> src/cfpe_engine.sv
// CAN bit-level frame engine: frame build and check, stuffing, CRC, error and overload frames
// Summary of operation
// - Identifier goes out MSB first, 11 bits standard, 29 bits extended.
// - Extended frames send substitute remote request recessive; standard frames omit it.
// - DLC 0-7 gives that many bytes; top bit set means 8 bytes.
// - Both reserved control bits are sent recessive.
// - Remote frames carry no data field whatever the DLC.
// - 15-bit CRC with the CAN generator polynomial, then a delimiter.
// - CRC covers SOF, arbitration, control and data, never stuff bits.
// - Receiver destuffs, rechecks the CRC and signals an error on mismatch.
// - An error-free receiver drives the acknowledge slot dominant.
// - Error-active interframe space is 3 intermission bits then idle.
// - Error-passive nodes add suspend transmission after intermission.
// - Pending transmit may start on a dominant third intermission bit when error-active.
// - Passive node waits for 11 recessive bits; active starts on idle.
// - Error flag is 6 dominant when active, 6 recessive when passive.
// - A foreign error flag shows as stuff error and draws our flag.
// - Delimiters are 8 recessive; dominant eighth bit starts overload frame.
// - Error frame starts next bit; CRC error waits for ACK delimiter.
// - Receiver not ready starts overload at the first intermission bit.
// - Dominant early intermission bit starts overload one bit later.
// - Dominant third intermission bit is a start of frame.
// - At most two receiver-not-ready overload frames delay the next frame; overloads answering dominant bits are not limited.
// - Overload flag is 6 dominant; seen overload flag is answered.
// - RTR dominant for data frames, recessive for remote frames.
// - IDE recessive for extended frames, dominant for standard ones.
// - After five equal bits insert an opposite bit; receiver deletes it.
// - Zero is dominant, one is recessive; dominant wins on the bus.
`timescale 1ns/100ps
module cfpe_engine
  import cfpe_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Bus side, one sample strobe per bit time
  input wire logic sample_pulse,
  input wire logic rx_bit,
  output logic tx_bit,
  // Node state
  input wire logic err_passive,
  // Transmit request
  input wire logic tx_valid,
  input wire cfpe_frame_t tx_frame,
  output logic tx_ready,
  // Receive header and data bytes
  output cfpe_hdr_t rx_hdr,
  output logic rx_ok,
  output logic rx_byte_valid,
  output logic [BYTE_W-1:0] rx_byte,
  input wire logic rx_byte_ready,
  // Events
  output logic tx_done,
  output logic arb_lost,
  output logic err_start,
  output logic ovl_start
);
  cfpe_state_t st_r, st_nxt;
  logic [6:0] cnt_r, cnt_nxt, dlast_r, dlast_nxt, head_last;
  logic [2:0] run_r, run_nxt;
  logic [1:0] ovl_cnt_r, ovl_cnt_nxt;
  logic [3:0] rec_run_r, rx_nb;
  logic [14:0] crc_r, crc_nxt;
  logic [38:0] head_r, head_nxt, head_in;
  logic [7:0] byte_r, byte_nxt, byte_in;
  logic [TXSH_W-1:0] txsh_r, txsh_nxt, img;
  logic [28:0] rx_id;
  logic last_r, last_nxt, ide_r, ide_nxt, xmit_r, xmit_nxt, pend_r, pend_nxt;
  logic crc_bad_r, crc_bad_nxt, is_ovl_r, is_ovl_nxt, tx_bit_r, tx_bit_nxt;
  logic tx_ready_r, rx_ok_r, rx_ok_nxt, tx_done_r, tx_done_nxt, arb_lost_r, arb_lost_nxt;
  logic err_r, ovl_r, err_go, ovl_go, sof_go, push, fifo_in_ready;
  logic in_stuff, stuff_slot, stuff_err, arb_zone, lose, tx_checked, bit_err, can_start;
  cfpe_hdr_t hdr_r, hdr_nxt;
  cfpe_frame_t frm_r;

  // Decode of the current bit
  assign in_stuff = st_r inside {S_HEAD, S_DATA, S_CRC, S_CRCD};
  assign stuff_slot = in_stuff && (run_r == STUFF_RUN);
  assign stuff_err = stuff_slot && (rx_bit == last_r);
  assign arb_zone = (st_r == S_HEAD) && !stuff_slot && (cnt_r != 7'h00) &&
                    ((cnt_r <= ARB_STD_LAST) || (ide_r && (cnt_r <= ARB_EXT_LAST)));
  // Recessive sent, dominant seen: someone else wins, no error
  assign lose = xmit_r && arb_zone && (tx_bit_r == REC) && (rx_bit == DOM);
  assign tx_checked = xmit_r && (st_r inside {S_HEAD, S_DATA, S_CRC, S_CRCD, S_ACKD, S_EOF});
  assign bit_err = tx_checked && (rx_bit != tx_bit_r) && !lose;
  assign can_start = pend_r && (!err_passive || (rec_run_r >= IDLE_RUN));
  assign head_last = ide_r ? HEAD_EXT_LAST : HEAD_STD_LAST;
  assign head_in = {head_r[37:0], rx_bit};
  assign byte_in = {byte_r[6:0], rx_bit};
  assign rx_nb = dlc_bytes(head_in[3:0]);
  assign rx_id = ide_r ? {head_in[37:27], head_in[24:7]} : {18'h00000, head_in[17:7]};
  assign img = tx_image(frm_r);
  assign push = sample_pulse && (st_r == S_DATA) && !stuff_slot && !xmit_r && (cnt_r[2:0] == BYTE_LAST);
  assign pend_nxt = tx_done_nxt ? 1'b0 : (pend_r || tx_valid);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    dlast_nxt = dlast_r;
    run_nxt = run_r;
    last_nxt = last_r;
    ide_nxt = ide_r;
    xmit_nxt = xmit_r;
    crc_nxt = crc_r;
    crc_bad_nxt = crc_bad_r;
    head_nxt = head_r;
    byte_nxt = byte_r;
    txsh_nxt = txsh_r;
    hdr_nxt = hdr_r;
    is_ovl_nxt = is_ovl_r;
    ovl_cnt_nxt = ovl_cnt_r;
    tx_bit_nxt = tx_bit_r;
    rx_ok_nxt = 1'b0;
    tx_done_nxt = 1'b0;
    arb_lost_nxt = 1'b0;
    err_go = 1'b0;
    ovl_go = 1'b0;
    sof_go = 1'b0;
    // All decisions are taken at the sample strobe only
    if (sample_pulse) begin
      if (in_stuff) begin
        run_nxt = (rx_bit == last_r) ? run_r + 3'h1 : 3'h1;
        last_nxt = rx_bit;
      end
      if (lose) begin
        xmit_nxt = 1'b0;
        arb_lost_nxt = 1'b1;
      end
      case (st_r)
        S_IDLE: begin
          if (rx_bit == DOM) begin
            sof_go = 1'b1;
          end else if (can_start) begin
            st_nxt = S_HEAD;
            cnt_nxt = 7'h00;
            xmit_nxt = 1'b1;
            txsh_nxt = img;
            crc_nxt = 15'h0000;
            ide_nxt = 1'b0;
            crc_bad_nxt = 1'b0;
            ovl_cnt_nxt = 2'h0;
            run_nxt = 3'h0;
            last_nxt = REC;
          end
        end
        S_HEAD: begin
          if (!stuff_slot) begin
            crc_nxt = crc_step(crc_r, rx_bit);
            head_nxt = head_in;
            txsh_nxt = txsh_r << 1;
            cnt_nxt = cnt_r + 7'h01;
            if (cnt_r == POS_IDE) begin
              ide_nxt = rx_bit;
            end
            if (cnt_r == head_last) begin
              hdr_nxt = '{ide: ide_r, rtr: head_in[RTR_BACK], id: rx_id, dlc: head_in[3:0]};
              cnt_nxt = 7'h00;
              dlast_nxt = {rx_nb[3:0] - 4'h1, BYTE_LAST};
              st_nxt = (head_in[RTR_BACK] || rx_nb == 4'h0) ? S_CRC : S_DATA;
            end
          end
        end
        S_DATA: begin
          if (!stuff_slot) begin
            crc_nxt = crc_step(crc_r, rx_bit);
            byte_nxt = byte_in;
            txsh_nxt = txsh_r << 1;
            cnt_nxt = cnt_r + 7'h01;
            if (cnt_r == dlast_r) begin
              cnt_nxt = 7'h00;
              st_nxt = S_CRC;
            end
          end
        end
        S_CRC: begin
          if (!stuff_slot) begin
            // Feeding the received sequence through leaves zero when it matches
            crc_nxt = crc_step(crc_r, rx_bit);
            cnt_nxt = cnt_r + 7'h01;
            if (cnt_r == CRC_LAST) begin
              crc_bad_nxt = crc_nxt != 15'h0000;
              st_nxt = S_CRCD;
            end
          end
        end
        S_CRCD: begin
          if (!stuff_slot) begin
            err_go = rx_bit == DOM;
            st_nxt = S_ACK;
          end
        end
        S_ACK: begin
          err_go = xmit_r && (rx_bit == REC);
          st_nxt = S_ACKD;
        end
        S_ACKD: begin
          // A CRC error is reported only once the ACK delimiter has passed
          err_go = (rx_bit == DOM) || crc_bad_r;
          st_nxt = S_EOF;
          cnt_nxt = 7'h00;
        end
        S_EOF: begin
          cnt_nxt = cnt_r + 7'h01;
          if (rx_bit == DOM) begin
            err_go = 1'b1;
          end else if (cnt_r == EOF_LAST) begin
            tx_done_nxt = xmit_r;
            rx_ok_nxt = !xmit_r;
            xmit_nxt = 1'b0;
            st_nxt = S_INTER;
            cnt_nxt = 7'h00;
            ovl_go = !fifo_in_ready && (ovl_cnt_r < MAX_OVL);
            ovl_cnt_nxt = ovl_cnt_r + {1'b0, ovl_go};
          end
        end
        S_INTER: begin
          cnt_nxt = cnt_r + 7'h01;
          if (rx_bit == DOM) begin
            sof_go = cnt_r == INTER_LAST;
            ovl_go = cnt_r != INTER_LAST;
          end else if (cnt_r == INTER_LAST) begin
            st_nxt = err_passive ? S_SUSP : S_IDLE;
            cnt_nxt = 7'h00;
          end
        end
        S_SUSP: begin
          cnt_nxt = cnt_r + 7'h01;
          if (rx_bit == DOM) begin
            sof_go = 1'b1;
          end else if (cnt_r == SUSP_LAST) begin
            st_nxt = S_IDLE;
          end
        end
        S_FLAG: begin
          cnt_nxt = cnt_r + 7'h01;
          if (cnt_r == FLAG_LAST) begin
            st_nxt = S_DWAIT;
          end
        end
        S_DWAIT: begin
          // Other nodes' flags may overlap ours; the delimiter starts at the first recessive bit
          if (rx_bit == REC) begin
            st_nxt = S_DELIM;
            cnt_nxt = 7'h01;
          end
        end
        S_DELIM: begin
          cnt_nxt = cnt_r + 7'h01;
          if (cnt_r == DELIM_LAST) begin
            // A receiver still not ready may hold off the next frame once more
            ovl_go = (rx_bit == DOM) || (!fifo_in_ready && (ovl_cnt_r < MAX_OVL));
            ovl_cnt_nxt = ovl_cnt_r + {1'b0, (rx_bit == REC) && ovl_go};
            st_nxt = S_INTER;
            cnt_nxt = 7'h00;
            is_ovl_nxt = 1'b0;
          end else begin
            err_go = rx_bit == DOM;
          end
        end
        default: begin
          st_nxt = S_IDLE;
        end
      endcase
      if (bit_err || stuff_err) begin
        err_go = 1'b1;
      end
      // Next bit to drive
      if (xmit_nxt) begin
        if (st_nxt == S_CRC) begin
          tx_bit_nxt = crc_nxt[14];
        end else if (st_nxt inside {S_HEAD, S_DATA}) begin
          tx_bit_nxt = txsh_nxt[TXSH_W-1];
        end else begin
          tx_bit_nxt = REC;
        end
        if ((st_nxt inside {S_HEAD, S_DATA, S_CRC, S_CRCD}) && (run_nxt == STUFF_RUN)) begin
          tx_bit_nxt = !last_nxt;
        end
      end else if (st_nxt == S_FLAG) begin
        tx_bit_nxt = tx_bit_r;
      end else begin
        tx_bit_nxt = (st_nxt == S_ACK && !crc_bad_nxt) ? DOM : REC;
      end
      if (err_go) begin
        st_nxt = S_FLAG;
        cnt_nxt = 7'h00;
        xmit_nxt = 1'b0;
        is_ovl_nxt = 1'b0;
        tx_bit_nxt = err_passive ? REC : DOM;
      end else if (ovl_go) begin
        st_nxt = S_FLAG;
        cnt_nxt = 7'h00;
        is_ovl_nxt = 1'b1;
        tx_bit_nxt = DOM;
      end else if (sof_go) begin
        st_nxt = S_HEAD;
        cnt_nxt = 7'h01;
        head_nxt = 39'h0;
        crc_nxt = 15'h0000;
        ide_nxt = 1'b0;
        crc_bad_nxt = 1'b0;
        ovl_cnt_nxt = 2'h0;
        run_nxt = 3'h1;
        last_nxt = DOM;
        tx_bit_nxt = REC;
        // When error-active, join a frame started by someone else in idle or in the third intermission bit
        if (pend_r && !err_passive) begin
          xmit_nxt = 1'b1;
          txsh_nxt = img << 1;
          tx_bit_nxt = img[TXSH_W-2];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= S_IDLE;
      cnt_r <= 7'h00;
      dlast_r <= 7'h00;
      run_r <= 3'h0;
      last_r <= REC;
      ide_r <= 1'b0;
      xmit_r <= 1'b0;
      pend_r <= 1'b0;
      crc_r <= 15'h0000;
      crc_bad_r <= 1'b0;
      head_r <= 39'h0;
      byte_r <= 8'h00;
      txsh_r <= '0;
      hdr_r <= '0;
      frm_r <= '0;
      is_ovl_r <= 1'b0;
      ovl_cnt_r <= 2'h0;
      rec_run_r <= 4'h0;
      tx_bit_r <= REC;
      tx_ready_r <= 1'b0;
      rx_ok_r <= 1'b0;
      tx_done_r <= 1'b0;
      arb_lost_r <= 1'b0;
      err_r <= 1'b0;
      ovl_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      dlast_r <= dlast_nxt;
      run_r <= run_nxt;
      last_r <= last_nxt;
      ide_r <= ide_nxt;
      xmit_r <= xmit_nxt;
      pend_r <= pend_nxt;
      crc_r <= crc_nxt;
      crc_bad_r <= crc_bad_nxt;
      head_r <= head_nxt;
      byte_r <= byte_nxt;
      txsh_r <= txsh_nxt;
      hdr_r <= hdr_nxt;
      is_ovl_r <= is_ovl_nxt;
      ovl_cnt_r <= ovl_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_ready_r <= !pend_nxt;
      rx_ok_r <= rx_ok_nxt;
      tx_done_r <= tx_done_nxt;
      arb_lost_r <= arb_lost_nxt;
      err_r <= err_go;
      ovl_r <= ovl_go && !err_go;
      if (sample_pulse) begin
        rec_run_r <= (rx_bit == DOM) ? 4'h0 : (rec_run_r == IDLE_RUN ? IDLE_RUN : rec_run_r + 4'h1);
      end
      // The frame is captured once; it is resent after any error until done
      if (!pend_r && tx_valid) begin
        frm_r <= tx_frame;
      end
    end
  end

  // Bytes are streamed as they arrive; the rx_ok pulse validates them
  cfpe_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(push),
    .in_data(byte_in),
    .in_ready(fifo_in_ready),
    .out_valid(rx_byte_valid),
    .out_data(rx_byte),
    .out_ready(rx_byte_ready)
  );

  assign tx_bit = tx_bit_r;
  assign tx_ready = tx_ready_r;
  assign rx_hdr = hdr_r;
  assign rx_ok = rx_ok_r;
  assign tx_done = tx_done_r;
  assign arb_lost = arb_lost_r;
  assign err_start = err_r;
  assign ovl_start = ovl_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  err_flag_level_a: assert property (err_start |-> tx_bit_r == $past(err_passive))
    else $error("error flag level does not follow error state");
  ovl_flag_dom_a: assert property (ovl_start |-> (tx_bit_r == DOM) && (st_r == S_FLAG) && is_ovl_r)
    else $error("overload flag not dominant");
  stuff_bit_a: assert property (sample_pulse && stuff_slot && xmit_r && !bit_err |-> tx_bit_r != last_r)
    else $error("stuff bit not opposite level");
  ack_drive_a: assert property (sample_pulse && st_r == S_CRCD && !stuff_slot && !xmit_r && !crc_bad_r &&
                                rx_bit == REC |=> tx_bit_r == DOM ##1 tx_bit_r == DOM)
    else $error("ack slot not driven dominant");
  crc_err_a: assert property (sample_pulse && st_r == S_ACKD && crc_bad_r |=> err_start && st_r == S_FLAG)
    else $error("crc error frame not after ack delimiter");
  inter_sof_a: assert property (sample_pulse && st_r == S_INTER && cnt_r == INTER_LAST &&
                                rx_bit == DOM |=> st_r == S_HEAD && cnt_r == 7'h01)
    else $error("third intermission dominant not taken as sof");
  ovl_limit_a: assert property (ovl_cnt_r <= MAX_OVL)
    else $error("too many overload frames");
  passive_susp_a: assert property (sample_pulse && st_r == S_INTER && cnt_r == INTER_LAST && rx_bit == REC &&
                                   err_passive |=> st_r == S_SUSP)
    else $error("passive node skipped suspend");
  idle_wait_a: assert property ($rose(xmit_r) && $past(st_r) == S_IDLE && $past(err_passive) |->
                                $past(rec_run_r) >= IDLE_RUN)
    else $error("passive node started too early");
  remote_nodata_a: assert property (sample_pulse && st_r == S_HEAD && !stuff_slot && cnt_r == head_last &&
                                    head_in[RTR_BACK] && !err_go |=> st_r == S_CRC)
    else $error("remote frame entered data field");
  delim_ovl_a: assert property (sample_pulse && st_r == S_DELIM && cnt_r == DELIM_LAST &&
                                rx_bit == DOM && !err_go |=> ovl_start)
    else $error("dominant eighth delimiter bit ignored");

  tx_done_c: cover property (tx_done);
  rx_ok_c: cover property (rx_ok);
  arb_lost_c: cover property (arb_lost);
  ovl_c: cover property (ovl_start ##[1:400] err_start);
endmodule : cfpe_engine

// >>> bench/cfpe_bus_node.sv
// Far-side CAN node: wired-AND bus, scripted bit sequence and optional acknowledge
`timescale 1ns/100ps
module cfpe_bus_node (
  // Clock
  input wire logic mclk,
  // Bit timing and bus levels
  input wire logic sample_pulse,
  input wire logic dut_tx,
  output logic bus_lvl
);
  logic drv = 1'b1;
  logic script_q[$];
  logic seen_q[$];
  int pos = -1;
  int ack_at = -1;
  assign bus_lvl = dut_tx & drv;
  // Own level moves only at the sample edge, so every bit stands one full bit time
  always @(posedge mclk) begin
    if (sample_pulse) begin
      int p;
      p = (pos >= 0) ? pos + 1 : (bus_lvl ? -1 : 0);
      pos <= p;
      seen_q.push_back(bus_lvl);
      if (p + 1 == ack_at) drv <= 1'b0;
      else if (script_q.size() > 0) drv <= script_q.pop_front();
      else drv <= 1'b1;
    end
  end
endmodule : cfpe_bus_node

// >>> bench/cfpe_engine_tb.sv
// Self-checking bench for the CAN frame engine
`timescale 1ns/100ps
module cfpe_engine_tb
  import cfpe_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic sample_pulse = 1'b0;
  logic err_passive = 1'b0;
  logic tx_valid = 1'b0;
  cfpe_frame_t tx_frame = '0;
  logic rx_byte_ready = 1'b1;
  logic rx_bit, tx_bit, tx_ready, rx_ok, rx_byte_valid, tx_done, arb_lost, err_start, ovl_start;
  logic [7:0] rx_byte;
  cfpe_hdr_t rx_hdr;
  logic [1:0] div = 2'h0;
  logic exp_q[$];
  logic [7:0] got_q[$];
  int err_total = 0, num_checks = 0, n_ok = 0, n_err = 0, n_ovl = 0, n_arb = 0, cyc = 0;

  cfpe_engine dut (.mclk(mclk), .resetn(resetn), .sample_pulse(sample_pulse), .rx_bit(rx_bit),
    .tx_bit(tx_bit), .err_passive(err_passive), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .tx_ready(tx_ready), .rx_hdr(rx_hdr), .rx_ok(rx_ok), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_byte_ready(rx_byte_ready), .tx_done(tx_done), .arb_lost(arb_lost),
    .err_start(err_start), .ovl_start(ovl_start));
  cfpe_bus_node node (.mclk(mclk), .sample_pulse(sample_pulse), .dut_tx(tx_bit), .bus_lvl(rx_bit));

  initial forever #20 mclk = ~mclk;
  // One bit time is four clocks
  always @(posedge mclk) begin
    div <= div + 2'h1;
    sample_pulse <= (div == 2'h2);
    cyc++;
    if (rx_ok === 1'b1) n_ok++;
    if (err_start === 1'b1) n_err++;
    if (ovl_start === 1'b1) n_ovl++;
    if (arb_lost === 1'b1) n_arb++;
    if (rx_byte_valid === 1'b1 && rx_byte_ready === 1'b1) got_q.push_back(rx_byte);
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic check(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      err_total++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : check

  // Unstuffed image, CRC and stuffing worked out independently of the design
  function automatic void build(input cfpe_frame_t f, input logic bad);
    logic u[$];
    logic [14:0] crc = 15'h0000;
    logic last = 1'b1;
    int run = 0;
    int n;
    u.push_back(1'b0);
    for (int i = 28; i >= 18; i--) u.push_back(f.id[f.ide ? i : i - 18]);
    if (f.ide) begin
      u.push_back(1'b1);
      u.push_back(1'b1);
      for (int i = 17; i >= 0; i--) u.push_back(f.id[i]);
    end
    u.push_back(f.rtr);
    u.push_back(f.ide ? 1'b1 : 1'b0);
    u.push_back(1'b1);
    for (int i = 3; i >= 0; i--) u.push_back(f.dlc[i]);
    n = f.rtr ? 0 : (f.dlc[3] ? 64 : 8 * f.dlc[2:0]);
    for (int i = 63; i > 63 - n; i--) u.push_back(f.data[i]);
    // Taps of x15+x14+x10+x8+x7+x4+x3+1
    foreach (u[i]) crc = {crc[13:0], 1'b0} ^ ((u[i] ^ crc[14]) ? 15'h4599 : 15'h0000);
    for (int i = 14; i >= 0; i--) u.push_back(crc[i] ^ (bad && i == 0));
    exp_q = {};
    foreach (u[i]) begin
      exp_q.push_back(u[i]);
      run = (u[i] == last) ? run + 1 : 1;
      last = u[i];
      if (run == 5) begin
        exp_q.push_back(!last);
        last = !last;
        run = 1;
      end
    end
    for (int i = 0; i < 10; i++) exp_q.push_back(i != 1);
  endfunction : build

  function automatic int first_dom();
    int s = 0;
    while (s < node.seen_q.size() && node.seen_q[s] !== 1'b0) s++;
    return s;
  endfunction : first_dom

  task automatic fresh(input cfpe_frame_t f, input logic bad);
    repeat (100) @(posedge mclk);
    @(negedge mclk);
    node.seen_q = {};
    node.pos = -1;
    node.ack_at = -1;
    n_ok = 0;
    n_err = 0;
    n_ovl = 0;
    n_arb = 0;
    got_q = {};
    build(f, bad);
  endtask : fresh

  task automatic scen_tx(input cfpe_frame_t f);
    fresh(f, 1'b0);
    node.ack_at = exp_q.size() - 9;
    @(posedge mclk);
    tx_frame <= f;
    tx_valid <= 1'b1;
    @(posedge mclk);
    tx_valid <= 1'b0;
    for (int i = 0; i < 3000 && tx_done !== 1'b1; i++) @(negedge mclk);
    check(tx_done === 1'b1, "no tx_done");
    @(negedge mclk);
    check(tx_ready === 1'b1, "tx_ready low after done");
    for (int i = 0; i < exp_q.size(); i++) check(node.seen_q[first_dom() + i] === exp_q[i], "tx bit");
    check(n_ok == 0, "rx_ok on own frame");
  endtask : scen_tx

  task automatic scen_arb();
    cfpe_frame_t f;
    f = cfpe_frame_t'{1'b0, 1'b0, 29'h00000180, 4'h1, 64'ha5000000_00000000};
    fresh(cfpe_frame_t'{1'b0, 1'b0, 29'h00000100, 4'h1, 64'h5a000000_00000000}, 1'b0);
    @(posedge mclk);
    tx_frame <= f;
    tx_valid <= 1'b1;
    @(posedge mclk);
    tx_valid <= 1'b0;
    @(negedge mclk);
    // Node starts in the same bit as the engine and wins with the lower identifier
    foreach (exp_q[i]) node.script_q.push_back(exp_q[i] | (i == exp_q.size() - 9));
    for (int i = 0; i < 1500 && rx_ok !== 1'b1; i++) @(negedge mclk);
    check(n_arb == 1 && rx_ok === 1'b1, "arbitration loss");
    check(rx_hdr.id === 29'h00000100, "winner header");
    // Rebase the node on the retried frame so that it acknowledges it
    node.pos = -1;
    build(f, 1'b0);
    node.ack_at = exp_q.size() - 9;
    for (int i = 0; i < 1500 && tx_done !== 1'b1; i++) @(negedge mclk);
    check(tx_done === 1'b1 && n_err == 0, "no retransmission");
  endtask : scen_arb

  task automatic scen_rx_ovl(input cfpe_frame_t f);
    int s;
    int l;
    fresh(f, 1'b0);
    l = exp_q.size();
    for (int i = 0; i < l; i++) node.script_q.push_back(exp_q[i] | (i == l - 9));
    @(posedge mclk);
    rx_byte_ready <= 1'b0;
    repeat (900) @(posedge mclk);
    s = first_dom();
    for (int i = 0; i < l; i++) check(node.seen_q[s + i] === exp_q[i], "rx bus bit");
    check(n_ok == 1, "no rx_ok");
    check(rx_hdr === {f.ide, f.rtr, f.id, f.dlc}, "rx_hdr");
    for (int k = 0; k < 6; k++) check(node.seen_q[s + l + k] === 1'b0, "overload flag");
    check(n_ovl == 2, "overload count");
    rx_byte_ready <= 1'b1;
    repeat (20) @(posedge mclk);
    check(got_q.size() == 8, "byte count");
    foreach (got_q[i]) check(got_q[i] === f.data[63 - 8 * i -: 8], "rx byte");
  endtask : scen_rx_ovl

  task automatic scen_crc(input logic passive);
    cfpe_frame_t f;
    int s;
    int l;
    f = cfpe_frame_t'{1'b0, 1'b0, 29'h00000321, 4'h2, 64'h84210000_00000000};
    fresh(f, 1'b1);
    l = exp_q.size();
    for (int i = 0; i < l - 8; i++) node.script_q.push_back(exp_q[i] | (i == l - 9));
    @(posedge mclk);
    err_passive <= passive;
    repeat (4 * l + 120) @(posedge mclk);
    s = first_dom();
    check(node.seen_q[s + l - 9] === 1'b1, "ack on bad crc");
    for (int k = 0; k < 6; k++) check(node.seen_q[s + l - 7 + k] === passive, "error flag");
    check(n_err == 1 && n_ok == 0, "crc error event");
    err_passive <= 1'b0;
  endtask : scen_crc

  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    scen_tx(cfpe_frame_t'{1'b1, 1'b0, 29'h0b5a3c71, 4'hc, 64'hf0e1d2c3b4a59687});
    scen_tx(cfpe_frame_t'{1'b0, 1'b1, 29'h000005a3, 4'h3, 64'hffff0000ffff0000});
    scen_rx_ovl(cfpe_frame_t'{1'b0, 1'b0, 29'h000000f0, 4'h8, 64'h0000ffff0123abcd});
    scen_arb();
    scen_crc(1'b0);
    scen_crc(1'b1);
    summarize();
  end
endmodule : cfpe_engine_tb
